// File: src/iof_frame_builder.sv
// i/o sample frame builder with avalon-mm register port and byte stream out
// assumes core_clk 50 MHz, sink applies back-pressure with txReady
`timescale 1ns/100ps
`default_nettype none

// What this block does
// R1: digital line mask at offset 16, bit 15 never set.
// R2: analog mask at offset 18, bit 7 only with supply monitoring on.
// R3: digital sample word at 19 only when digital mask nonzero.
// R4: lines without sampling enabled read zero in the sample word.
// R5: sample bit position equals mask bit position.
// R6: one 16-bit result per enabled analog input, none for disabled.
// R7: analog results emitted in ascending channel order 0 to 3.
// R8: last byte is 0xFF minus low byte of sum from offset 3.
// R9: stuffing option 1 carries frame bytes unmodified.
// R10: type 0x92 frame only in api mode with standard output format.
// R11: delimiter at offset 0, then length of bytes from offset 3 up to the checksum.
// R12: source address, reserved word, receive options, sample count.
// R13: analog follows digital word or mask; supply result follows last input.
// R14: multi-byte fields msb first, length follows included fields.
module iof_frame_builder
    import iof_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             txValid,
    output iof_byte_t        txOut,
    input  wire logic        txReady
);
    logic [31:0] regFile [NREG];
    iof_state_t  state_reg;
    logic [4:0]  pos_reg;
    logic [7:0]  sum_reg;
    logic [15:0] frameCount_reg;
    logic        rdDone_reg;
    logic        outValid_reg;
    iof_byte_t   out_reg;
    logic [31:0] rdData_reg;

    wire logic [3:0]  wordIdx   = avs_address[5:2];
    wire logic        busy      = (state_reg == IOF_EMIT);
    wire logic        wrAccept  = ce && avs_write && !busy;
    wire logic        rdAccept  = ce && avs_read && !rdDone_reg;

    // field views
    wire logic        apiMode   = regFile[IDX_CTRL][CTRL_API];
    wire logic [1:0]  outFormat = regFile[IDX_CTRL][CTRL_FMT_LSB +: 2];
    wire logic [1:0]  stuffOpt  = regFile[IDX_CTRL][CTRL_STUF_LSB +: 2];
    wire logic        supplyEn  = regFile[IDX_CTRL][CTRL_SUPPLY];
    wire logic [15:0] dMask     = regFile[IDX_MASKS][15:0] & DMASK_LINES; // R1
    wire logic [7:0]  aMaskRaw  = regFile[IDX_MASKS][23:16];
    wire logic [7:0]  aMask     = {supplyEn & aMaskRaw[SUPPLY_BIT],
                                   3'b000, aMaskRaw[3:0]}; // R2
    wire logic [15:0] dLevels   = regFile[IDX_DIGITAL][15:0];
    wire logic [15:0] dSampEn   = regFile[IDX_DIGITAL][31:16];
    wire logic [15:0] dSample   = dLevels & dSampEn & dMask; // R4 R5
    wire logic        dPresent  = (dMask != 16'h0000); // R3
    // R13: supply result sits after channel 3
    wire logic [4:0]  chEn      = {aMask[SUPPLY_BIT], aMask[3:0]};

    // R14: length grows by two per optional word
    function automatic logic [15:0] frameLen(input logic dp, input logic [4:0] en);
        logic [15:0] n;
        n = LEN_FIXED;
        if (dp) begin
            n = n + LEN_WORD;
        end
        for (int i = 0; i < 5; i++) begin
            if (en[i]) begin
                n = n + LEN_WORD;
            end
        end
        return n;
    endfunction : frameLen

    wire logic [15:0] lenField = frameLen(dPresent, chEn); // R14

    // full layout, msb first, every optional field in its slot
    wire logic [8*FRAME_BYTES-1:0] frameVec = {
        FRAME_DELIM, lenField, FRAME_TYPE,               // R11 R10
        regFile[IDX_ADDR_HI], regFile[IDX_ADDR_LO],      // R12
        regFile[IDX_RXINFO][31:16],
        regFile[IDX_RXINFO][7:0], regFile[IDX_RXINFO][15:8],
        dMask, aMask, dSample,                           // R1 R2 R3
        regFile[IDX_ANA01][31:16], regFile[IDX_ANA01][15:0], // R7
        regFile[IDX_ANA23][31:16], regFile[IDX_ANA23][15:0],
        regFile[IDX_SUPPLY][15:0]};

    // skip absent optional slots so the next present field follows directly
    wire logic [4:0]  anaOff    = pos_reg - POS_ANA_FIRST;
    wire logic [2:0]  anaCh     = anaOff[3:1];
    wire logic        isDig     = (pos_reg == POS_DIG_HI) || (pos_reg == POS_DIG_LO);
    wire logic        isAna     = (pos_reg >= POS_ANA_FIRST) && (pos_reg <= POS_LAST_DATA);
    wire logic        included  = isDig ? dPresent :
                                  isAna ? chEn[anaCh] : 1'b1; // R3 R6 R13
    wire logic [7:0]  vecIdx    = 8'(FRAME_BYTES - 1) - {3'b000, pos_reg};
    wire logic [7:0]  dataByte  = frameVec[8*vecIdx +: 8];
    wire logic        isCheck   = (pos_reg == POS_CHECKSUM);
    wire logic [7:0]  checkByte = CHECK_BASE - sum_reg; // R8
    // R9: bytes leave unmodified, no escape insertion
    wire logic [7:0]  srcByte   = isCheck ? checkByte : dataByte;
    wire logic        srcValid  = busy && included;
    wire logic        outFree   = !outValid_reg || txReady;
    wire logic        take      = ce && srcValid && outFree;
    wire logic        advance   = ce && busy && (!included || outFree);
    wire logic        inSum     = (pos_reg >= POS_TYPE) && !isCheck; // R8
    wire logic        eligible  = apiMode && (outFormat == FMT_STANDARD); // R10
    wire logic        trigger   = wrAccept && (wordIdx == IDX_TRIGGER) && eligible;

    // register read view
    wire logic [31:0] statusWord = {frameCount_reg, 8'h00, 3'b000, stuffOpt,
                                    eligible, dPresent, busy};
    wire logic [31:0] rdView;
    assign rdView = (wordIdx == IDX_STATUS) ? statusWord :
                    (wordIdx < IDX_TRIGGER) ? regFile[wordIdx] : RST_ZERO;

    // writes stall while a frame is out so its fields stay fixed
    assign avs_waitrequest = !ce || (avs_read && !rdDone_reg) || (avs_write && busy);
    assign avs_readdata    = rdData_reg;
    assign txValid         = outValid_reg;
    assign txOut           = out_reg;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : gen_reg
            localparam logic [31:0] RST = (g == IDX_CTRL)   ? RST_CTRL :
                                          (g == IDX_RXINFO) ? RST_RXINFO : RST_ZERO;
            logic        hit;
            logic [31:0] merged;
            assign hit = wrAccept && (wordIdx == 4'(g)) && (g != IDX_STATUS);
            for (genvar b = 0; b < 4; b++) begin : gen_be
                assign merged[8*b +: 8] = avs_byteenable[b] ? avs_writedata[8*b +: 8]
                                                            : regFile[g][8*b +: 8];
            end
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    regFile[g] <= RST;
                end else if (hit) begin
                    regFile[g] <= merged;
                end
            end
        end
    endgenerate

    // one wait cycle per read, data registered
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdDone_reg <= 1'b0;
            rdData_reg <= RST_ZERO;
        end else if (ce) begin
            rdDone_reg <= rdAccept;
            if (rdAccept) begin
                rdData_reg <= rdView;
            end
        end
    end

    // frame sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg      <= IOF_IDLE;
            pos_reg        <= 5'd0;
            sum_reg        <= 8'h00;
            frameCount_reg <= 16'h0000;
        end else if (ce) begin
            case (state_reg)
                IOF_IDLE: begin
                    if (trigger) begin
                        state_reg <= IOF_EMIT;
                        pos_reg   <= 5'd0;
                        sum_reg   <= 8'h00;
                    end
                end
                IOF_EMIT: begin
                    if (take && inSum) begin
                        sum_reg <= sum_reg + srcByte; // R8
                    end
                    if (advance) begin
                        pos_reg <= pos_reg + 5'd1;
                        if (isCheck) begin
                            state_reg      <= IOF_IDLE;
                            frameCount_reg <= frameCount_reg + 16'h0001;
                        end
                    end
                end
                default: state_reg <= IOF_IDLE;
            endcase
        end
    end

    // output holding stage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            outValid_reg <= 1'b0;
            out_reg      <= '0;
        end else if (ce && outFree) begin
            outValid_reg <= srcValid;
            if (srcValid) begin
                out_reg <= '{data: srcByte, last: isCheck};
            end
        end
    end
endmodule : iof_frame_builder

`default_nettype wire

// File: src/iof_pkg.sv
// constants, register map and stream carrier for the i/o sample frame builder
// assumes a 32-bit avalon-mm register port and a byte-wide streaming sink
package iof_pkg;
    // frame bytes and field positions within the full frame layout
    localparam logic [7:0] FRAME_DELIM    = 8'h7E;
    localparam logic [7:0] FRAME_TYPE     = 8'h92;
    localparam logic [4:0] POS_TYPE       = 5'd3;
    localparam logic [4:0] POS_DIG_HI     = 5'd19;
    localparam logic [4:0] POS_DIG_LO     = 5'd20;
    localparam logic [4:0] POS_ANA_FIRST  = 5'd21;
    localparam logic [4:0] POS_LAST_DATA  = 5'd30;
    localparam logic [4:0] POS_CHECKSUM   = 5'd31;
    localparam int         FRAME_BYTES    = 31;
    localparam logic [7:0] CHECK_BASE     = 8'hFF;
    localparam logic [15:0] LEN_FIXED     = 16'h0010;
    localparam logic [15:0] LEN_WORD      = 16'h0002;
    localparam logic [15:0] DMASK_LINES   = 16'h7FFF;
    localparam int         SUPPLY_BIT     = 7;
    localparam int         ANA_CH         = 4;
    localparam logic [1:0] FMT_STANDARD   = 2'b00;

    // register word indices (byte address = 4 * index)
    localparam int         NREG           = 10;
    localparam logic [3:0] IDX_CTRL       = 4'h0;
    localparam logic [3:0] IDX_STATUS     = 4'h1;
    localparam logic [3:0] IDX_ADDR_HI    = 4'h2;
    localparam logic [3:0] IDX_ADDR_LO    = 4'h3;
    localparam logic [3:0] IDX_RXINFO     = 4'h4;
    localparam logic [3:0] IDX_MASKS      = 4'h5;
    localparam logic [3:0] IDX_DIGITAL    = 4'h6;
    localparam logic [3:0] IDX_ANA01      = 4'h7;
    localparam logic [3:0] IDX_ANA23      = 4'h8;
    localparam logic [3:0] IDX_SUPPLY     = 4'h9;
    localparam logic [3:0] IDX_TRIGGER    = 4'hA;

    // control field positions
    localparam int CTRL_API      = 0;
    localparam int CTRL_FMT_LSB  = 1;
    localparam int CTRL_STUF_LSB = 3;
    localparam int CTRL_SUPPLY   = 5;

    localparam logic [31:0] RST_CTRL   = 32'h0000_0009;
    localparam logic [31:0] RST_RXINFO = 32'hFFFE_0100;
    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;

    typedef enum logic {IOF_IDLE, IOF_EMIT} iof_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } iof_byte_t;
endpackage : iof_pkg

// File: tb/iof_frame_builder_asserts.sv
// checker for the frame builder ports
// assumes binding onto iof_frame_builder, one clock domain
`timescale 1ns/100ps
`default_nettype none
module iof_frame_builder_asserts
    import iof_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        ce,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        txValid,
    input wire iof_byte_t   txOut,
    input wire logic        txReady
);
    logic [5:0]  idxReg;
    logic [7:0]  sumReg;
    logic [15:0] lenReg;
    wire logic   take;
    assign take = txValid && txReady;
    // byte index and running sum of the frame in flight
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            idxReg <= '0;
            sumReg <= '0;
            lenReg <= '0;
        end else if (take) begin
            idxReg <= txOut.last ? 6'd0 : idxReg + 6'd1;
            sumReg <= txOut.last ? 8'd0 : (idxReg >= 6'd3 ? sumReg + txOut.data : sumReg);
            if (idxReg == 6'd1) lenReg[15:8] <= txOut.data;
            if (idxReg == 6'd2) lenReg[7:0] <= txOut.data;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_stall_hold: assert property (txValid && !txReady |=> txValid && $stable(txOut))
        else $error("stalled byte changed");
    a_ce_waits: assert property (!ce |-> avs_waitrequest)
        else $error("bus answered with clock enable low");
    a_delim_first: assert property (txValid && idxReg == 6'd0 |-> txOut.data == FRAME_DELIM)
        else $error("frame does not open with delimiter");
    a_type_code: assert property (txValid && idxReg == 6'd3 |-> txOut.data == FRAME_TYPE)
        else $error("wrong frame type byte");
    a_mask_bit15: assert property (txValid && idxReg == 6'd16 |-> !txOut.data[7])
        else $error("digital mask bit 15 set");
    a_check_sum: assert property (txValid && txOut.last |-> 8'(sumReg + txOut.data) == CHECK_BASE)
        else $error("bad checksum");
    a_len_match: assert property (txValid && txOut.last |-> idxReg == lenReg[5:0] + 6'd3)
        else $error("length field does not match frame");
    a_no_early: assert property (txValid && idxReg < 6'd19 |-> !txOut.last)
        else $error("frame ended too early");
    cover property (take && txOut.last);
    cover property (txValid && !txReady);
    cover property (avs_read && !avs_waitrequest);
endmodule : iof_frame_builder_asserts
bind iof_frame_builder iof_frame_builder_asserts i_chk (.core_clk(core_clk), .nrst(nrst),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txValid(txValid),
    .txOut(txOut), .txReady(txReady));
`default_nettype wire

// File: tb/iof_host_sink.sv
// host side byte sink collecting frames
// assumes the builder's stream handshake
`timescale 1ns/100ps
`default_nettype none
module iof_host_sink
    import iof_pkg::*;
(
    input wire logic  core_clk,
    input wire logic  nrst,
    input wire logic  stall,
    input wire logic  txValid,
    input wire iof_byte_t txOut,
    output logic      txReady,
    output logic [7:0] csErr
);
    logic [7:0] got[$];
    logic [7:0] s;
    int         n;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) txReady <= 1'b0;
        else txReady <= stall ? ~txReady : 1'b1;
    end
    initial csErr = 8'h00;
    always @(posedge core_clk) begin
        if (txValid && txReady) begin
            got.push_back(txOut.data);
            if (txOut.last) begin
                s = 8'h00;
                for (n = 3; n < got.size() - 1; n++) s += got[n];
                if (8'(s + txOut.data) !== 8'hFF) csErr <= csErr + 8'd1;
            end
        end
    end
endmodule : iof_host_sink
`default_nettype wire

// File: tb/iof_frame_builder_tb.sv
// self-checking bench for the frame builder
// assumes iof_pkg, the host sink model and the checker
`timescale 1ns/100ps
`default_nettype none
module iof_frame_builder_tb
    import iof_pkg::*;
;
    logic core_clk, nrst, ce, avs_read, avs_write, txValid, txReady, stall, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] csErr;
    logic [7:0] exp[$];
    iof_byte_t txOut;
    int num_errors, tests_run;
    iof_frame_builder i_dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .txValid(txValid), .txOut(txOut), .txReady(txReady));
    iof_host_sink i_host (.core_clk(core_clk), .nrst(nrst), .stall(stall),
        .txValid(txValid), .txOut(txOut), .txReady(txReady), .csErr(csErr));
    always #10 core_clk = ~core_clk;
    function automatic logic [5:0] ra(logic [3:0] i);
        return {i, 2'b00};
    endfunction : ra
    task automatic check(logic [31:0] seen, logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic wr(logic [5:0] a, logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(logic [5:0] a, logic [31:0] want);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        check(avs_readdata, want);
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : rd
    task automatic ld(logic [63:0] a, logic [31:0] ri, m, d, an01, an23, sup);
        wr(ra(IDX_ADDR_HI), a[63:32]);
        wr(ra(IDX_ADDR_LO), a[31:0]);
        wr(ra(IDX_RXINFO), ri);
        wr(ra(IDX_MASKS), m);
        wr(ra(IDX_DIGITAL), d);
        wr(ra(IDX_ANA01), an01);
        wr(ra(IDX_ANA23), an23);
        wr(ra(IDX_SUPPLY), sup);
    endtask : ld
    // expected frame from the field values
    function automatic void build(logic [63:0] a, logic [31:0] ri, logic [15:0] dm,
                                  logic [7:0] am, logic [15:0] dg, logic [79:0] an);
        logic [7:0] s;
        exp = {8'h7E, 8'h00, 8'h00, 8'h92};
        for (int i = 7; i >= 0; i--) exp.push_back(a[8*i+:8]);
        exp.push_back(ri[31:24]);
        exp.push_back(ri[23:16]);
        exp.push_back(ri[7:0]);
        exp.push_back(ri[15:8]);
        exp.push_back(dm[15:8]);
        exp.push_back(dm[7:0]);
        exp.push_back(am);
        if (dm != 16'h0000) begin
            exp.push_back(dg[15:8]);
            exp.push_back(dg[7:0]);
        end
        for (int i = 0; i < 5; i++) if (am[i == 4 ? 7 : i]) begin
            exp.push_back(an[79-16*i-:8]);
            exp.push_back(an[71-16*i-:8]);
        end
        exp[2] = 8'(exp.size() - 3);
        s = 8'h00;
        for (int i = 3; i < exp.size(); i++) s += exp[i];
        exp.push_back(8'hFF - s);
    endfunction : build
    task automatic frame();
        int n;
        i_host.got.delete();
        wr(ra(IDX_TRIGGER), 32'h0000_0000);
        for (n = 0; n < 300 && i_host.got.size() < exp.size(); n++) @(posedge core_clk);
        check(i_host.got.size(), exp.size());
        foreach (exp[i]) check(i_host.got[i], exp[i]);
    endtask : frame
    task automatic t_reset();
        rd(ra(IDX_CTRL), RST_CTRL);
        rd(ra(IDX_RXINFO), RST_RXINFO);
        rd(6'h2C, RST_ZERO);
        avs_byteenable <= 4'h1;
        wr(ra(IDX_ADDR_HI), 32'hAABB_CCDD);
        avs_byteenable <= 4'hF;
        rd(ra(IDX_ADDR_HI), 32'h0000_00DD);
    endtask : t_reset
    task automatic t_example();
        stall <= 1'b1;
        ld(64'h0013_A200_1234_5678, 32'hFFFE_01C1, 32'h0006_0038, 32'hFFFF_0028,
           32'h0000_0225, 32'h00F8_0000, 32'h0000_0000);
        build(64'h0013_A200_1234_5678, 32'hFFFE_01C1, 16'h0038, 8'h06, 16'h0028,
              80'h0000_0225_00F8_0000_0000);
        frame();
        stall <= 1'b0;
    endtask : t_example
    task automatic t_analog();
        wr(ra(IDX_CTRL), 32'h0000_0029);
        ld(64'h7E7D_1122_3344_5566, 32'h1234_0302, 32'h008F_0000, 32'h0000_0000,
           32'h0102_0304, 32'h0506_0708, 32'h0000_0ABC);
        build(64'h7E7D_1122_3344_5566, 32'h1234_0302, 16'h0000, 8'h8F, 16'h0000,
              80'h0102_0304_0506_0708_0ABC);
        frame();
        wr(ra(IDX_CTRL), RST_CTRL);
    endtask : t_analog
    task automatic t_digital();
        ld(64'h0000_0000_0000_0001, 32'hFFFE_0101, 32'h00F0_C0F1, 32'h00F0_FFFF,
           32'h1111_1111, 32'h2222_2222, 32'h0000_3333);
        build(64'h0000_0000_0000_0001, 32'hFFFE_0101, 16'h40F1, 8'h00, 16'h00F0, 80'h0);
        frame();
    endtask : t_digital
    task automatic t_refuse();
        logic [31:0] c[2] = '{32'h0000_000B, 32'h0000_0008};
        foreach (c[k]) begin
            wr(ra(IDX_CTRL), c[k]);
            i_host.got.delete();
            wr(ra(IDX_TRIGGER), 32'h0000_0000);
            repeat (40) @(posedge core_clk);
            check(i_host.got.size(), 0);
        end
        wr(ra(IDX_CTRL), RST_CTRL);
        rd(ra(IDX_STATUS), 32'h0003_000E);
    endtask : t_refuse
    task automatic final_report();
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    initial begin
        #400000;
        num_errors++;
        final_report();
    end
    initial begin
        core_clk = 0; nrst = 0; ce = 0; stall = 0; avs_read = 0; avs_write = 0;
        avs_address = '0; avs_writedata = '0; avs_byteenable = 4'hF;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        check(avs_waitrequest, 1'b1);
        ce <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_example();
        t_analog();
        t_digital();
        t_refuse();
        check(csErr, 8'h00);
        final_report();
    end
endmodule : iof_frame_builder_tb
`default_nettype wire
